// file: tb/stm16_far_end_model.sv
// Purpose: Far end section source feeding the link
// Assumes: Frames back to back, COLS columns
// Notes:   Bytes change on the link falling edge
`timescale 1ns/1ps
module stm16_far_end_model
  import stm16_ms_pkg::*;
#(
  parameter int COLS = 192
) (
  // Link
  output logic            link_clk,
  output stream_s         tx,
  // Overhead values
  input  wire logic [2:0] k2_code,
  input  wire logic [7:0] m1_val,
  input  wire logic [7:0] b2_flip
);
  int         r, c;
  logic [7:0] b;
  logic [7:0] par [B2_BYTES];
  logic [7:0] acc [B2_BYTES];
  initial begin
    link_clk = 1'b0;
    tx = '0;
    r = 0;
    c = 0;
    foreach (par[i]) begin
      par[i] = 8'h00;
      acc[i] = 8'h00;
    end
    forever begin
      #16 link_clk = 1'b1;
      #16 link_clk = 1'b0;
      b = c[7:0];
      if (r == B2_ROW && c < B2_BYTES) b = par[c] ^ b2_flip;
      if (r == K2_ROW && c == K2_COL) b = {5'h00, k2_code};
      if (r == M1_ROW && c == M1_COL) b = m1_val;
      if (r >= RSOH_ROWS || c >= RSOH_COLS) acc[c % B2_BYTES] ^= b;
      tx.fs = (r == 0 && c == 0);
      tx.data = b;
      c++;
      if (c == COLS) begin
        c = 0;
        r++;
      end
      if (r == FRAME_ROWS) begin
        r = 0;
        par = acc;
        foreach (acc[i]) acc[i] = 8'h00;
      end
    end
  end
endmodule

// file: tb/stm16_ms_trail_termination_properties.sv
// Purpose: Port assertions for the trail termination
// Assumes: One pclk domain
// Notes:   Bound below the module
`timescale 1ns/1ps
module stm16_ms_tt_properties
  import stm16_ms_pkg::*;
(
  // Clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // Watched ports
  input wire logic    incoming_server_fail,
  input wire logic    snk_out_valid,
  input wire stream_s snk_out,
  input wire logic    all_ones_insert_action,
  input wire logic    trail_fail_action,
  input wire logic    trail_degrade_action,
  input wire logic    remote_defect_request,
  input wire status_s status
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ais_act: assert property (
    all_ones_insert_action == status.section_alarm_defect) else $error("ais act");
  chk_tsf_act: assert property (
    trail_fail_action == status.section_alarm_defect) else $error("tsf act");
  chk_rdi_req: assert property (
    remote_defect_request == status.section_alarm_defect) else $error("rdi req");
  chk_tsd_act: assert property (
    trail_degrade_action == status.signal_degrade_defect) else $error("tsd act");
  chk_ais_gate: assert property (
    status.alarm_report |-> status.section_alarm_defect && !incoming_server_fail) else $error("ais gate");
  chk_ssf_gate: assert property (
    status.server_fail_report |-> status.section_alarm_defect) else $error("ssf gate");
  chk_deg_gate: assert property (
    status.degrade_report |-> status.signal_degrade_defect) else $error("deg gate");
  chk_rdi_gate: assert property (
    status.far_defect_report |-> status.far_receiver_defect) else $error("rdi gate");
  chk_ones_out: assert property (
    snk_out_valid && all_ones_insert_action && $past(all_ones_insert_action, 4) |-> snk_out.data == ALL_ONES)
    else $error("ones");
  chk_ais_hold: assert property (
    $changed(status.section_alarm_defect) |=> $stable(status.section_alarm_defect) [*8]) else $error("ais hold");
  cover property ($rose(status.section_alarm_defect));
  cover property ($rose(status.signal_degrade_defect));
  cover property ($rose(status.far_receiver_defect));
endmodule

bind stm16_ms_trail_termination stm16_ms_tt_properties i_props (
  .pclk, .presetn, .incoming_server_fail, .snk_out_valid, .snk_out, .all_ones_insert_action,
  .trail_fail_action, .trail_degrade_action, .remote_defect_request, .status);

// file: tb/stm16_ms_trail_termination_tb_top.sv
// Purpose: Self-checking bench for the trail termination
// Assumes: Far end model feeds both streams
// Notes:   Short frames of COLS columns
`timescale 1ns/1ps
module stm16_ms_trail_termination_tb_top
  import stm16_ms_pkg::*;
;
  localparam int COLS = 192;
  localparam int K2P  = K2_ROW * COLS + K2_COL;
  localparam int M1P  = M1_ROW * COLS + M1_COL;
  localparam int PP   = 1000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rd_e, link_clk;
  logic        src_out_valid, snk_out_valid, incoming_server_fail, equipment_defect, one_second_tick;
  logic        all_ones_insert_action, trail_fail_action, trail_degrade_action, remote_defect_request;
  logic [2:0]  k2_code;
  logic [7:0]  paddr, remote_error_count_request, m1_val, b2_flip, sb, sbp;
  logic [15:0] sn, kn, sp = 16'h8000, kp = 16'h8000;
  logic [31:0] pwdata, prdata, rd_q;
  stream_s     lnk, src_out, snk_out;
  status_s     status;
  int          compares, miscompares;
  stm16_ms_trail_termination #(.FRAME_COLS(COLS)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk, .src_in(lnk), .src_out, .src_out_valid,
    .snk_in(lnk), .snk_out, .snk_out_valid, .incoming_server_fail, .equipment_defect, .one_second_tick,
    .all_ones_insert_action, .trail_fail_action, .trail_degrade_action, .remote_defect_request,
    .remote_error_count_request, .status, .irq);
  stm16_far_end_model #(.COLS(COLS)) i_far (.link_clk, .tx(lnk), .k2_code, .m1_val, .b2_flip);
  assign sn = src_out.fs ? 16'h0000 : sp + 16'h0001;
  assign kn = snk_out.fs ? 16'h0000 : kp + 16'h0001;
  always @(posedge pclk) begin
    if (src_out_valid) sp <= sn;
    if (snk_out_valid) kp <= kn;
    if (src_out_valid && src_out.fs) {sbp, sb} <= {sb, 8'h00};
    if (src_out_valid && sn % B2_BYTES == 1 && (sn >= RSOH_ROWS * COLS || sn % COLS >= RSOH_COLS))
      sb <= sb ^ src_out.data;
  end
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      miscompares++;
      $display("MISMATCH %s exp %0h got %0h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, rd_q, x);
  endtask
  task automatic at(input logic k, input int p);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (!(k ? snk_out_valid && kn == p : src_out_valid && sn == p) && n < 20000);
    chk("position", n < 20000, 1'b1);
  endtask
  task automatic pulse;
    repeat (4) @(posedge pclk);
    one_second_tick <= 1'b1;
    @(posedge pclk);
    one_second_tick <= 1'b0;
  endtask
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, one_second_tick, equipment_defect, incoming_server_fail, presetn} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    k2_code = K2_RDI;
    m1_val = 8'h07;
    b2_flip = 8'h01;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", REG_CTRL, 32'h6F);
    rdc("deg thr", REG_DEG_THR, 32'h10);
    rdc("mask", REG_INT_MASK, 32'h0);
    rdc("hole", 8'h40, 32'h0);
    chk("hole err", rd_e, 1'b1);
    apb(1'b1, REG_DEG_PER, 32'h1);
    rdc("deg per", REG_DEG_PER, 32'h1);
    $display("test regs done");
    at(1'b0, K2P);
    chk("src k2", src_out.data[2:0], K2_NORMAL);
    apb(1'b1, REG_CTRL, 32'h7F);
    at(1'b0, B2_ROW * COLS + 1);
    chk("src b2", src_out.data, sbp);
    at(1'b0, K2P);
    chk("ring k2", src_out.data[2:0], K2_RDI);
    at(1'b0, M1P);
    chk("src m1", src_out.data, 8'h30);
    chk("rei", remote_error_count_request, 8'h30);
    apb(1'b1, REG_CTRL, 32'h6F);
    $display("test source done");
    at(1'b1, PP);
    chk("data", snk_out.data, 8'(PP % COLS));
    at(1'b1, M1P);
    pulse;
    equipment_defect <= 1'b1;
    at(1'b1, M1P);
    pulse;
    equipment_defect <= 1'b0;
    rdc("near ebc", REG_NEAR_EBC, 32'h30);
    rdc("far ebc", REG_FAR_EBC, 32'h7);
    rdc("pm flags", REG_PM_FLAGS, 32'h3);
    rdc("status", REG_STATUS, 32'h36);
    chk("rdi", status.far_receiver_defect, 1'b1);
    chk("rdi rep", status.far_defect_report, 1'b1);
    chk("deg", status.signal_degrade_defect, 1'b1);
    chk("tsd", trail_degrade_action, 1'b1);
    chk("deg rep", status.degrade_report, 1'b1);
    $display("test monitor done");
    k2_code <= K2_AIS;
    b2_flip <= 8'hFF;
    repeat (3) at(1'b1, K2P);
    chk("ais", status.section_alarm_defect, 1'b1);
    chk("acts", {all_ones_insert_action, trail_fail_action, remote_defect_request}, 3'h7);
    chk("ais rep", status.alarm_report, 1'b1);
    chk("ssf rep", status.server_fail_report, 1'b1);
    chk("rdi off", status.far_receiver_defect, 1'b0);
    @(posedge pclk);
    incoming_server_fail <= 1'b1;
    @(posedge pclk);
    #1 chk("ais gated", status.alarm_report, 1'b0);
    @(posedge pclk);
    incoming_server_fail <= 1'b0;
    at(1'b1, PP);
    chk("ones", snk_out.data, ALL_ONES);
    at(1'b0, M1P);
    chk("clip", src_out.data, REI_MAX);
    rdc("int stat", REG_INT_STAT, 32'h1F);
    chk("irq off", irq, 1'b0);
    apb(1'b1, REG_INT_MASK, 32'h1);
    #1 chk("irq on", irq, 1'b1);
    apb(1'b1, REG_INT_STAT, 32'h1);
    #1 chk("irq clr", irq, 1'b0);
    at(1'b0, K2P);
    chk("src rdi", src_out.data[2:0], K2_RDI);
    $display("test alarm done");
    complete_run;
  end
  initial begin
    #550000;
    miscompares++;
    $display("MISMATCH watchdog exp done got hang");
    complete_run;
  end
endmodule

// file: verilog/stm16_frame_pos_bip.sv
// Purpose: Frame position tracking and interleaved parity of the previous frame
// Assumes: byte_en marks one byte; fs high on the first byte of a frame
// Notes:   Position outputs describe the byte presented in the same cycle
`timescale 1ns/1ps
module stm16_frame_pos_bip
  import stm16_ms_pkg::*;
#(
  parameter int COLS = FRAME_COLS_DEF
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Byte stream
  input  wire logic                byte_en,
  input  wire logic                fs,
  input  wire logic [7:0]          data,
  // Position and parity
  output logic                     in_b2,
  output logic                     in_k2,
  output logic                     in_m1,
  output logic                     b2_last,
  output logic [5:0]               b2_index,
  output logic [BIP_BITS-1:0]      bip_prev
);

  localparam int CW = $clog2(COLS);

  logic [CW-1:0] col_q;
  logic [CW-1:0] col_cur;
  logic [3:0]    row_q;
  logic [3:0]    row_cur;
  logic [5:0]    lane_q;
  logic [5:0]    lane_cur;
  logic          in_rsoh;
  logic [7:0]    acc_q [B2_BYTES];
  logic [7:0]    bip_q [B2_BYTES];

  // Next position
  always_comb begin
    col_cur  = col_q + CW'(1);
    row_cur  = row_q;
    lane_cur = (lane_q == 6'(B2_BYTES - 1)) ? 6'h00 : lane_q + 6'h01;
    if (fs) begin
      col_cur  = '0;
      row_cur  = '0;
      lane_cur = '0;
    end else if (col_q == CW'(COLS - 1)) begin
      col_cur  = '0;
      lane_cur = '0;
      row_cur  = (row_q == 4'(FRAME_ROWS - 1)) ? 4'h0 : row_q + 4'h1;
    end
  end

  assign in_rsoh  = (row_cur < 4'(RSOH_ROWS)) && (col_cur < CW'(RSOH_COLS));
  assign in_b2    = (row_cur == 4'(B2_ROW)) && (col_cur < CW'(B2_BYTES));
  assign in_k2    = (row_cur == 4'(K2_ROW)) && (col_cur == CW'(K2_COL));
  assign in_m1    = (row_cur == 4'(M1_ROW)) && (col_cur == CW'(M1_COL));
  assign b2_last  = in_b2 && (lane_cur == 6'(B2_BYTES - 1));
  assign b2_index = lane_cur;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_q  <= CW'(COLS - 1);
      row_q  <= 4'(FRAME_ROWS - 1);
      lane_q <= 6'(B2_BYTES - 1);
    end else if (byte_en) begin
      col_q  <= col_cur;
      row_q  <= row_cur;
      lane_q <= lane_cur;
    end
  end

  // same parity for the receive side
  for (genvar g = 0; g < B2_BYTES; g++) begin : g_lane
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_q[g] <= '0;
        bip_q[g] <= '0;
      end else if (byte_en) begin
        if (fs) begin
          bip_q[g] <= acc_q[g];
          acc_q[g] <= (lane_cur == 6'(g) && !in_rsoh) ? data : 8'h00;
        end else if (lane_cur == 6'(g) && !in_rsoh) begin
          acc_q[g] <= acc_q[g] ^ data;
        end
      end
    end
    assign bip_prev[g*8 +: 8] = bip_q[g];
  end

endmodule

// file: verilog/stm16_ms_pkg.sv
// Purpose: Shared constants and types for the STM-16 multiplex section trail termination
// Assumes: Byte-wide frame stream, 9 rows by FRAME_COLS columns per frame
// Notes:   Register map is APB, one aligned 32-bit word per register
package stm16_ms_pkg;

  // Frame geometry
  localparam int FRAME_ROWS     = 9;
  localparam int FRAME_COLS_DEF = 4320;
  localparam int RSOH_ROWS      = 3;
  localparam int RSOH_COLS      = 144;
  localparam int B2_ROW         = 4;
  localparam int B2_BYTES       = 48;
  localparam int BIP_BITS       = 384;
  localparam int K2_ROW         = 4;
  localparam int K2_COL         = 96;
  localparam int M1_ROW         = 8;
  localparam int M1_COL         = 146;

  // Overhead codes
  localparam logic [2:0] K2_RDI    = 3'h6;
  localparam logic [2:0] K2_AIS    = 3'h7;
  localparam logic [2:0] K2_NORMAL = 3'h0;
  localparam logic [7:0] REI_MAX   = 8'hFF;
  localparam logic [7:0] ALL_ONES  = 8'hFF;
  localparam logic [2:0] FILT_MIN  = 3'h3;
  localparam logic [2:0] FILT_MAX  = 3'h5;

  // Register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_DEG_THR  = 8'h04;
  localparam logic [7:0] REG_DEG_PER  = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam logic [7:0] REG_INT_STAT = 8'h10;
  localparam logic [7:0] REG_INT_MASK = 8'h14;
  localparam logic [7:0] REG_NEAR_EBC = 8'h18;
  localparam logic [7:0] REG_FAR_EBC  = 8'h1C;
  localparam logic [7:0] REG_PM_FLAGS = 8'h20;

  // Field widths and reset values
  localparam int          DEG_THR_W     = 16;
  localparam int          DEG_PER_W     = 4;
  localparam int          INT_W         = 5;
  localparam logic [7:0]  CTRL_RESET    = 8'h6F;
  localparam logic [15:0] DEG_THR_RESET = 16'h0010;
  localparam logic [3:0]  DEG_PER_RESET = 4'h7;

  // Interrupt bit positions
  localparam int INT_AIS  = 0;
  localparam int INT_DEG  = 1;
  localparam int INT_RDI  = 2;
  localparam int INT_SEC  = 3;
  localparam int INT_NEAR = 4;

  typedef struct packed {
    logic [2:0] filter_frames;
    logic       ring_mode;
    logic       server_fail_reporting_enable;
    logic       far_defect_reporting_enable;
    logic       alarm_reporting_enable;
    logic       termination_point_monitor_mode;
  } ctrl_s;

  typedef struct packed {
    logic       server_fail_report;
    logic       far_defect_report;
    logic       degrade_report;
    logic       alarm_report;
    logic       far_receiver_defect;
    logic       signal_degrade_defect;
    logic       section_alarm_defect;
  } status_s;

  typedef struct packed {
    logic       fs;
    logic [7:0] data;
  } stream_s;

endpackage

// file: verilog/stm16_ms_trail_termination.sv
// Purpose: STM-16 multiplex section trail termination, source and sink halves with APB registers
// Assumes: link_clk and both streams come from outside and are sampled by pclk
// Notes:   Overhead actions take effect after filtering, from the byte after the one that carries them
`timescale 1ns/1ps
module stm16_ms_trail_termination
  import stm16_ms_pkg::*;
#(
  parameter int FRAME_COLS = FRAME_COLS_DEF
) (
  // APB slave
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Link side
  input  wire logic          link_clk,
  input  wire stream_s       src_in,
  output stream_s            src_out,
  output logic               src_out_valid,
  input  wire stream_s       snk_in,
  output stream_s            snk_out,
  output logic               snk_out_valid,
  // Local conditions
  input  wire logic          incoming_server_fail,
  input  wire logic          equipment_defect,
  input  wire logic          one_second_tick,
  // Actions and indications
  output logic               all_ones_insert_action,
  output logic               trail_fail_action,
  output logic               trail_degrade_action,
  output logic               remote_defect_request,
  output logic [7:0]         remote_error_count_request,
  output status_s            status,
  output logic               irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0]           lclk_q;
  logic                 byte_en;
  stream_s              src_s1_q;
  stream_s              src_s2_q;
  stream_s              snk_s1_q;
  stream_s              snk_s2_q;
  ctrl_s                ctrl_q;
  logic [DEG_THR_W-1:0] deg_thr_q;
  logic [DEG_PER_W-1:0] deg_per_q;
  logic [INT_W-1:0]     int_stat_q;
  logic [INT_W-1:0]     int_mask_q;
  logic [INT_W-1:0]     int_ev;
  logic [INT_W-1:0]     int_clr;
  logic                 src_b2;
  logic                 src_k2pos;
  logic                 src_m1;
  logic [5:0]           src_lane;
  logic [BIP_BITS-1:0]  src_bip;
  logic [2:0]           src_k2;
  logic [7:0]           src_byte;
  logic                 snk_b2;
  logic                 snk_k2pos;
  logic                 snk_m1;
  logic                 snk_last;
  logic [5:0]           snk_lane;
  logic [BIP_BITS-1:0]  snk_bip;
  logic [3:0]           pop;
  logic [8:0]           err_acc_q;
  logic [8:0]           near_sum;
  logic [8:0]           near_frame_q;
  logic                 near_evt_q;
  logic [7:0]           far_frame_q;
  logic                 far_evt_q;
  logic [7:0]           rei_q;
  logic [2:0]           filt_x;
  logic                 k2_evt;
  logic                 flt_match [2];
  logic                 flt_q     [2];
  logic [2:0]           run_q     [2];
  logic                 deg_q;
  logic [DEG_PER_W-1:0] deg_run_q;
  logic                 bad_sec;
  logic [31:0]          near_add;
  logic [31:0]          far_add;
  logic [31:0]          sec_near_q;
  logic [31:0]          sec_far_q;
  logic [31:0]          near_ebc_q;
  logic [31:0]          far_ebc_q;
  logic                 nds_acc_q;
  logic                 fds_acc_q;
  logic                 near_ds_q;
  logic                 far_ds_q;
  logic [2:0]           def_prev_q;
  logic                 mon;
  logic                 wr_en;
  logic                 addr_bad;
  logic [31:0]          rd_mux;
  logic [31:0]          prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_q   <= '0;
      src_s1_q <= '0;
      src_s2_q <= '0;
      snk_s1_q <= '0;
      snk_s2_q <= '0;
    end else begin
      lclk_q   <= {lclk_q[1:0], link_clk};
      src_s1_q <= src_in;
      src_s2_q <= src_s1_q;
      snk_s1_q <= snk_in;
      snk_s2_q <= snk_s1_q;
    end
  end

  assign byte_en = lclk_q[1] & ~lclk_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Source half
  stm16_frame_pos_bip #(
    .COLS     (FRAME_COLS)
  ) u_src_pos (
    .pclk     (pclk),
    .presetn  (presetn),
    .byte_en  (byte_en),
    .fs       (src_s2_q.fs),
    .data     (src_byte),
    .in_b2    (src_b2),
    .in_k2    (src_k2pos),
    .in_m1    (src_m1),
    .b2_last  (),
    .b2_index (src_lane),
    .bip_prev (src_bip)
  );

  always_comb begin
    src_k2 = src_s2_q.data[2:0];
    if (remote_defect_request) begin
      src_k2 = K2_RDI;
    end else if (!ctrl_q.ring_mode && (src_k2 == K2_AIS || src_k2 == K2_RDI)) begin
      src_k2 = K2_NORMAL;
    end
    src_byte = src_s2_q.data;
    if (src_b2) begin
      src_byte = src_bip[{src_lane, 3'h0} +: 8];
    end else if (src_m1) begin
      src_byte = rei_q;
    end else if (src_k2pos) begin
      src_byte = {src_s2_q.data[7:3], src_k2};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_out       <= '0;
      src_out_valid <= 1'b0;
    end else begin
      src_out_valid <= byte_en;
      if (byte_en) begin
        src_out <= '{fs: src_s2_q.fs, data: src_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sink half
  stm16_frame_pos_bip #(
    .COLS     (FRAME_COLS)
  ) u_snk_pos (
    .pclk     (pclk),
    .presetn  (presetn),
    .byte_en  (byte_en),
    .fs       (snk_s2_q.fs),
    .data     (snk_s2_q.data),
    .in_b2    (snk_b2),
    .in_k2    (snk_k2pos),
    .in_m1    (snk_m1),
    .b2_last  (snk_last),
    .b2_index (snk_lane),
    .bip_prev (snk_bip)
  );

  // Mismatching bits in this B2 byte
  always_comb begin
    pop = 4'h0;
    for (int i = 0; i < 8; i++) begin
      pop = pop + {3'h0, snk_s2_q.data[i] ^ snk_bip[{snk_lane, 3'h0} + 9'(i)]};
    end
  end

  assign near_sum = err_acc_q + {5'h00, pop};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_acc_q    <= '0;
      near_frame_q <= '0;
      near_evt_q   <= 1'b0;
      rei_q        <= '0;
    end else begin
      near_evt_q <= 1'b0;
      if (byte_en && snk_b2) begin
        if (snk_last) begin
          err_acc_q    <= '0;
          near_frame_q <= near_sum;
          near_evt_q   <= 1'b1;
          rei_q        <= (near_sum > {1'b0, REI_MAX}) ? REI_MAX : near_sum[7:0];
        end else begin
          err_acc_q <= near_sum;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      far_frame_q <= '0;
      far_evt_q   <= 1'b0;
    end else begin
      far_evt_q <= byte_en && snk_m1;
      if (byte_en && snk_m1) begin
        far_frame_q <= snk_s2_q.data;
      end
    end
  end

  assign filt_x = (ctrl_q.filter_frames < FILT_MIN) ? FILT_MIN :
                  (ctrl_q.filter_frames > FILT_MAX) ? FILT_MAX : ctrl_q.filter_frames;
  assign k2_evt = byte_en && snk_k2pos;
  assign flt_match[0] = (snk_s2_q.data[2:0] == K2_AIS);
  assign flt_match[1] = (snk_s2_q.data[2:0] == K2_RDI);

  for (genvar g = 0; g < 2; g++) begin : g_flt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flt_q[g] <= 1'b0;
        run_q[g] <= '0;
      end else if (k2_evt) begin
        if (flt_match[g] != flt_q[g]) begin
          if (run_q[g] + 3'h1 >= filt_x) begin
            flt_q[g] <= flt_match[g];
            run_q[g] <= '0;
          end else begin
            run_q[g] <= run_q[g] + 3'h1;
          end
        end else begin
          run_q[g] <= '0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snk_out       <= '0;
      snk_out_valid <= 1'b0;
    end else begin
      snk_out_valid <= byte_en;
      if (byte_en) begin
        snk_out <= '{fs: snk_s2_q.fs, data: (flt_q[0] ? ALL_ONES : snk_s2_q.data)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Degrade and per second monitoring
  assign near_add = near_evt_q ? {23'h000000, near_frame_q} : 32'h00000000;
  assign far_add  = far_evt_q ? {24'h000000, far_frame_q} : 32'h00000000;
  assign bad_sec  = (sec_near_q + near_add) >= {16'h0000, deg_thr_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deg_q     <= 1'b0;
      deg_run_q <= '0;
    end else if (one_second_tick) begin
      if (bad_sec != deg_q) begin
        if (deg_run_q + 4'h1 >= deg_per_q) begin
          deg_q     <= bad_sec;
          deg_run_q <= '0;
        end else begin
          deg_run_q <= deg_run_q + 4'h1;
        end
      end else begin
        deg_run_q <= '0;
      end
    end
  end

  // error block sums and defect seconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_near_q <= '0;
      sec_far_q  <= '0;
      near_ebc_q <= '0;
      far_ebc_q  <= '0;
      nds_acc_q  <= 1'b0;
      fds_acc_q  <= 1'b0;
      near_ds_q  <= 1'b0;
      far_ds_q   <= 1'b0;
    end else if (one_second_tick) begin
      near_ebc_q <= sec_near_q + near_add;
      far_ebc_q  <= sec_far_q + far_add;
      sec_near_q <= '0;
      sec_far_q  <= '0;
      near_ds_q  <= nds_acc_q | trail_fail_action | equipment_defect;
      far_ds_q   <= fds_acc_q | flt_q[1];
      nds_acc_q  <= trail_fail_action | equipment_defect;
      fds_acc_q  <= flt_q[1];
    end else begin
      sec_near_q <= sec_near_q + near_add;
      sec_far_q  <= sec_far_q + far_add;
      nds_acc_q  <= nds_acc_q | trail_fail_action | equipment_defect;
      fds_acc_q  <= fds_acc_q | flt_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Actions and reports
  assign mon = ctrl_q.termination_point_monitor_mode;
  assign all_ones_insert_action     = flt_q[0];
  assign trail_fail_action          = flt_q[0];
  assign remote_defect_request      = flt_q[0];
  assign trail_degrade_action       = deg_q;
  assign remote_error_count_request = rei_q;

  always_comb begin
    status.section_alarm_defect  = flt_q[0];
    status.signal_degrade_defect = deg_q;
    status.far_receiver_defect   = flt_q[1];
    status.alarm_report       = mon & flt_q[0] & ~incoming_server_fail & ctrl_q.alarm_reporting_enable;
    status.server_fail_report = mon & flt_q[0] & ctrl_q.server_fail_reporting_enable;
    status.degrade_report     = mon & deg_q;
    status.far_defect_report  = mon & flt_q[1] & ctrl_q.far_defect_reporting_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  assign int_ev[INT_AIS]  = flt_q[0] & ~def_prev_q[0];
  assign int_ev[INT_DEG]  = deg_q & ~def_prev_q[1];
  assign int_ev[INT_RDI]  = flt_q[1] & ~def_prev_q[2];
  assign int_ev[INT_SEC]  = one_second_tick;
  assign int_ev[INT_NEAR] = near_evt_q && (near_frame_q != 9'h000);
  assign int_clr          = (wr_en && paddr == REG_INT_STAT) ? pwdata[INT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      def_prev_q <= '0;
      int_stat_q <= '0;
    end else begin
      def_prev_q <= {flt_q[1], deg_q, flt_q[0]};
      int_stat_q <= (int_stat_q & ~int_clr) | int_ev;
    end
  end

  assign irq = |(int_stat_q & int_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  assign wr_en   = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & addr_bad;
  assign prdata  = prdata_q;

  always_comb begin
    rd_mux   = 32'h00000000;
    addr_bad = 1'b0;
    case (paddr)
      REG_CTRL:     rd_mux = {24'h000000, ctrl_q};
      REG_DEG_THR:  rd_mux = {16'h0000, deg_thr_q};
      REG_DEG_PER:  rd_mux = {28'h0000000, deg_per_q};
      REG_STATUS:   rd_mux = {25'h0000000, status};
      REG_INT_STAT: rd_mux = {27'h0000000, int_stat_q};
      REG_INT_MASK: rd_mux = {27'h0000000, int_mask_q};
      REG_NEAR_EBC: rd_mux = near_ebc_q;
      REG_FAR_EBC:  rd_mux = far_ebc_q;
      REG_PM_FLAGS: rd_mux = {30'h00000000, far_ds_q, near_ds_q};
      default:      addr_bad = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable) begin
      prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= ctrl_s'(CTRL_RESET);
      deg_thr_q  <= DEG_THR_RESET;
      deg_per_q  <= DEG_PER_RESET;
      int_mask_q <= '0;
    end else if (wr_en) begin
      case (paddr)
        REG_CTRL:     ctrl_q     <= ctrl_s'(pwdata[7:0]);
        REG_DEG_THR:  deg_thr_q  <= pwdata[DEG_THR_W-1:0];
        REG_DEG_PER:  deg_per_q  <= pwdata[DEG_PER_W-1:0];
        REG_INT_MASK: int_mask_q <= pwdata[INT_W-1:0];
        default:      ;
      endcase
    end
  end

endmodule
